// file: logic/ffm_pkg.sv
// Operation
// - Host writes never alter the source register.
// - Event-active bit sets when combination is true.
// - Latch mode holds the triggering event's flags.
// - Interrupt is event-active qualified by enable and route.
// - Per-axis event flags, zero when axis disabled.
// - Per-axis polarity, negative g reads one.
// - Clear mode zeroes counter when condition drops.
// - Decrement mode counts down to zero, one step.
// - Clear mode acts alike for both threshold kinds.
// - Common threshold: seven bits, 63 mg steps.
// - Per-axis enable low selects the common threshold.
// - Per-axis enable high selects 13-bit axis thresholds.
// - Axis thresholds share the sample data scaling.
// - Threshold bit placement in high/low registers, reset zero.
// - Motion ORs enabled axes, freefall ANDs them.
// - Latched flags clear when the source is read.
// - Absolute sample values meet the thresholds.
// - Event at debounce target, counter never counts up beyond it.
`default_nettype none

package ffm_pkg;
    localparam int SAMPLE_W = 14;
    localparam int THR_W    = 13;
    localparam int CMP_W    = 16;
    localparam int CNT_W    = 8;
    localparam int AXES     = 3;

    localparam logic [7:0] ADDR_CFG   = 8'h15;
    localparam logic [7:0] ADDR_SRC   = 8'h16;
    localparam logic [7:0] ADDR_THS   = 8'h17;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    localparam logic [7:0] ADDR_X_HI  = 8'h73;
    localparam logic [7:0] ADDR_X_LO  = 8'h74;
    localparam logic [7:0] ADDR_Y_HI  = 8'h75;
    localparam logic [7:0] ADDR_Y_LO  = 8'h76;
    localparam logic [7:0] ADDR_Z_HI  = 8'h77;
    localparam logic [7:0] ADDR_Z_LO  = 8'h78;

    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] CFG_WMASK  = 8'hf8;
    localparam logic [7:0] LO_WMASK   = 8'hfc;
    localparam logic [7:0] Z_HI_WMASK = 8'h7f;
    localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;

    localparam int CFG_LATCH  = 7;
    localparam int CFG_MOTION = 6;
    localparam int CFG_ZEN    = 5;
    localparam int CFG_YEN    = 4;
    localparam int CFG_XEN    = 3;
    localparam int SRC_EA     = 7;
    localparam int THS_DBCLR  = 7;
    localparam int HI_FLAG    = 7;
    localparam int HI_FIELD   = 6;
    localparam int LO_FIELD   = 2;
    localparam int LO_TOP     = 7;
    localparam int COMMON_TOP = 6;

    // Common threshold weight in sample counts at the 2 g range.
    localparam int COMMON_MG_PER_LSB = 63;
    localparam int COUNTS_PER_G_2G   = 4096;
    localparam int MG_PER_G          = 1000;
    localparam logic [CMP_W-1:0] COMMON_STEP_2G =
        CMP_W'(COMMON_MG_PER_LSB * COUNTS_PER_G_2G / MG_PER_G);

    function automatic logic [CMP_W-1:0] join_thr(input logic [7:0] hi, input logic [7:0] lo);
        return {{(CMP_W-THR_W){1'b0}}, hi[HI_FIELD:0], lo[LO_TOP:LO_FIELD]};
    endfunction

    // Each range step doubles the sample weight, so the fixed mg step shifts right.
    function automatic logic [CMP_W-1:0] scale_common(input logic [6:0] ths,
                                                      input logic [1:0] fs);
        logic [CMP_W-1:0] prod;
        prod = CMP_W'(ths) * COMMON_STEP_2G;
        return prod >> fs;
    endfunction

    function automatic logic [CMP_W-1:0] abs_mag(input logic [SAMPLE_W-1:0] s);
        logic signed [CMP_W-1:0] ext;
        ext = CMP_W'(signed'(s));
        return ext[CMP_W-1] ? CMP_W'(-ext) : CMP_W'(ext);
    endfunction
endpackage

`default_nettype wire

// file: logic/ffm_axis_cmp.sv
`default_nettype none

module ffm_axis_cmp (
    input  wire logic [ffm_pkg::SAMPLE_W-1:0] sample,
    input  wire logic [ffm_pkg::CMP_W-1:0]    thresh,
    input  wire logic                         motion_mode,
    input  wire logic                         axis_en,
    output logic                              hit,
    output logic                              negative
);
    logic [ffm_pkg::CMP_W-1:0] magnitude;

    always_comb
    begin
        magnitude = ffm_pkg::abs_mag(sample);
        hit       = axis_en & (motion_mode ? (magnitude > thresh)
                                           : (magnitude < thresh));
        negative  = axis_en & sample[ffm_pkg::SAMPLE_W-1];
    end
endmodule // ffm_axis_cmp

`default_nettype wire

// file: logic/ffm_debounce.sv
`default_nettype none

module ffm_debounce (
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    input  wire logic                      sample_valid,
    input  wire logic                      cond,
    input  wire logic                      clear_mode,
    input  wire logic [ffm_pkg::CNT_W-1:0] target,
    output logic [ffm_pkg::CNT_W-1:0]      count_val,
    output logic                           reached
);
    logic [ffm_pkg::CNT_W-1:0] cnt_q;
    logic [ffm_pkg::CNT_W-1:0] cnt_d;

    // On a true sample, a target lowered below the count pulls the count down to it.
    always_comb
    begin
        cnt_d = cnt_q;
        if (sample_valid)
        begin
            if (cond)
                cnt_d = (cnt_q < target) ? cnt_q + ffm_pkg::CNT_STEP : target;
            else if (clear_mode)
                cnt_d = '0;
            else if (cnt_q != '0)
                cnt_d = cnt_q - ffm_pkg::CNT_STEP;
        end
        reached = sample_valid & cond & (cnt_d == target);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign count_val = cnt_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    property p_db_clear;
        sample_valid && !cond && clear_mode |=> cnt_q == '0;
    endproperty
    a_db_clear: assert property (p_db_clear) else $error("debounce not cleared");

    property p_db_dec;
        sample_valid && !cond && !clear_mode && cnt_q != '0 && cnt_q <= target
            |=> cnt_q == $past(cnt_q) - ffm_pkg::CNT_STEP;
    endproperty
    a_db_dec: assert property (p_db_dec) else $error("debounce not decremented");

    // A count left above a lowered target may stay above it through a false sample.
    property p_db_cap;
        sample_valid && (cond || cnt_q <= target) |=> cnt_q <= $past(target);
    endproperty
    a_db_cap: assert property (p_db_cap) else $error("debounce passed target");

    property p_db_idle;
        !sample_valid |=> $stable(cnt_q);
    endproperty
    a_db_idle: assert property (p_db_idle) else $error("count moved without sample");

    c_db_full: cover property (sample_valid && cond && cnt_q == target && target != '0);
endmodule // ffm_debounce

`default_nettype wire

// file: logic/ffm_detector.sv
`default_nettype none

module ffm_detector (
    input  wire logic                         sys_clk,
    input  wire logic                         srst,
    input  wire logic                         sample_valid,
    input  wire logic [ffm_pkg::SAMPLE_W-1:0] x_sample,
    input  wire logic [ffm_pkg::SAMPLE_W-1:0] y_sample,
    input  wire logic [ffm_pkg::SAMPLE_W-1:0] z_sample,
    input  wire logic [1:0]                   full_scale_select,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [7:0]                   reg_wdata,
    output logic [7:0]                        reg_rdata,
    input  wire logic                         ffmt_int_enable,
    input  wire logic                         ffmt_int_route,
    output logic                              int1_ffmt,
    output logic                              int2_ffmt,
    output logic                              event_active_flag,
    output logic                              trans_ths_share
);
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] ths_q;
    logic [7:0] ths_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] x_hi_q;
    logic [7:0] x_hi_d;
    logic [7:0] x_lo_q;
    logic [7:0] x_lo_d;
    logic [7:0] y_hi_q;
    logic [7:0] y_hi_d;
    logic [7:0] y_lo_q;
    logic [7:0] y_lo_d;
    logic [7:0] z_hi_q;
    logic [7:0] z_hi_d;
    logic [7:0] z_lo_q;
    logic [7:0] z_lo_d;
    logic [7:0] src_q;
    logic [7:0] src_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [ffm_pkg::SAMPLE_W-1:0] samples [ffm_pkg::AXES];
    logic [ffm_pkg::CMP_W-1:0]    thr     [ffm_pkg::AXES];
    logic [ffm_pkg::AXES-1:0]     axis_en;
    logic [ffm_pkg::AXES-1:0]     hit;
    logic [ffm_pkg::AXES-1:0]     neg;
    logic                         per_axis;
    logic                         motion;
    logic                         latch;
    logic                         cond;
    logic                         db_hit;
    logic                         rd_src;
    logic [7:0]                   live;
    logic [7:0]                   src_view;
    logic [7:0]                   view_mask;

    assign per_axis = x_hi_q[ffm_pkg::HI_FLAG];
    assign motion   = cfg_q[ffm_pkg::CFG_MOTION];
    assign latch    = cfg_q[ffm_pkg::CFG_LATCH];
    assign axis_en  = {cfg_q[ffm_pkg::CFG_ZEN], cfg_q[ffm_pkg::CFG_YEN], cfg_q[ffm_pkg::CFG_XEN]};
    assign rd_src   = reg_rd && (reg_addr == ffm_pkg::ADDR_SRC);

    assign samples[0] = x_sample;
    assign samples[1] = y_sample;
    assign samples[2] = z_sample;

    // Axis thresholds already sit in sample counts; only the common one is rescaled.
    always_comb
    begin
        if (per_axis)
        begin
            thr[0] = ffm_pkg::join_thr(x_hi_q, x_lo_q);
            thr[1] = ffm_pkg::join_thr(y_hi_q, y_lo_q);
            thr[2] = ffm_pkg::join_thr(z_hi_q, z_lo_q);
        end
        else
        begin
            thr[0] = ffm_pkg::scale_common(ths_q[ffm_pkg::COMMON_TOP:0],
                                           full_scale_select);
            thr[1] = thr[0];
            thr[2] = thr[0];
        end
    end

    for (genvar a = 0; a < ffm_pkg::AXES; a++)
    begin : g_axis
        ffm_axis_cmp u_cmp (
            .sample      (samples[a]),
            .thresh      (thr[a]),
            .motion_mode (motion),
            .axis_en     (axis_en[a]),
            .hit         (hit[a]),
            .negative    (neg[a])
        );
    end

    // Freefall with no axis enabled never fires, rather than firing on an empty AND.
    assign cond = motion ? (|hit) : ((|axis_en) & (&(hit | ~axis_en)));

    ffm_debounce u_db (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .sample_valid (sample_valid),
        .cond         (cond),
        .clear_mode   (ths_q[ffm_pkg::THS_DBCLR]),
        .target       (count_q),
        .count_val    (),
        .reached      (db_hit)
    );

    assign live = {db_hit, 1'b0, hit[2], neg[2], hit[1], neg[1], hit[0], neg[0]};

    // Configuration registers; the source address is not decoded for writes.
    always_comb
    begin
        cfg_d   = cfg_q;
        ths_d   = ths_q;
        count_d = count_q;
        x_hi_d  = x_hi_q;
        x_lo_d  = x_lo_q;
        y_hi_d  = y_hi_q;
        y_lo_d  = y_lo_q;
        z_hi_d  = z_hi_q;
        z_lo_d  = z_lo_q;
        if (reg_wr)
        begin
            unique case (reg_addr)
                ffm_pkg::ADDR_CFG:   cfg_d   = reg_wdata & ffm_pkg::CFG_WMASK;
                ffm_pkg::ADDR_THS:   ths_d   = reg_wdata;
                ffm_pkg::ADDR_COUNT: count_d = reg_wdata;
                ffm_pkg::ADDR_X_HI:  x_hi_d  = reg_wdata;
                ffm_pkg::ADDR_X_LO:  x_lo_d  = reg_wdata & ffm_pkg::LO_WMASK;
                ffm_pkg::ADDR_Y_HI:  y_hi_d  = reg_wdata;
                ffm_pkg::ADDR_Y_LO:  y_lo_d  = reg_wdata & ffm_pkg::LO_WMASK;
                ffm_pkg::ADDR_Z_HI:  z_hi_d  = reg_wdata & ffm_pkg::Z_HI_WMASK;
                ffm_pkg::ADDR_Z_LO:  z_lo_d  = reg_wdata & ffm_pkg::LO_WMASK;
                default:             cfg_d   = cfg_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cfg_q   <= ffm_pkg::RST_BYTE;
            ths_q   <= ffm_pkg::RST_BYTE;
            count_q <= ffm_pkg::RST_BYTE;
            x_hi_q  <= ffm_pkg::RST_BYTE;
            x_lo_q  <= ffm_pkg::RST_BYTE;
            y_hi_q  <= ffm_pkg::RST_BYTE;
            y_lo_q  <= ffm_pkg::RST_BYTE;
            z_hi_q  <= ffm_pkg::RST_BYTE;
            z_lo_q  <= ffm_pkg::RST_BYTE;
        end
        else
        begin
            cfg_q   <= cfg_d;
            ths_q   <= ths_d;
            count_q <= count_d;
            x_hi_q  <= x_hi_d;
            x_lo_q  <= x_lo_d;
            y_hi_q  <= y_hi_d;
            y_lo_q  <= y_lo_d;
            z_hi_q  <= z_hi_d;
            z_lo_q  <= z_lo_d;
        end
    end

    // Source register. In latch mode a fresh trigger in the read cycle
    // is loaded after the clear, so the event is not lost.
    always_comb
    begin
        src_d = src_q;
        if (!latch)
        begin
            if (sample_valid)
                src_d = live;
        end
        else
        begin
            if (rd_src)
                src_d = ffm_pkg::RST_BYTE;
            if (sample_valid && (!src_q[ffm_pkg::SRC_EA] || rd_src))
                src_d = live;
            else if (rd_src)
                src_d = ffm_pkg::RST_BYTE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            src_q <= ffm_pkg::RST_BYTE;
        else
            src_q <= src_d;
    end

    // Disabled axes read zero even if they were captured while enabled.
    assign view_mask = {2'b10, {2{axis_en[2]}}, {2{axis_en[1]}}, {2{axis_en[0]}}};
    assign src_view  = src_q & view_mask;

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ffm_pkg::ADDR_CFG:   rdata_d = cfg_q;
                ffm_pkg::ADDR_SRC:   rdata_d = src_view;
                ffm_pkg::ADDR_THS:   rdata_d = ths_q;
                ffm_pkg::ADDR_COUNT: rdata_d = count_q;
                ffm_pkg::ADDR_X_HI:  rdata_d = x_hi_q;
                ffm_pkg::ADDR_X_LO:  rdata_d = x_lo_q;
                ffm_pkg::ADDR_Y_HI:  rdata_d = y_hi_q;
                ffm_pkg::ADDR_Y_LO:  rdata_d = y_lo_q;
                ffm_pkg::ADDR_Z_HI:  rdata_d = z_hi_q;
                ffm_pkg::ADDR_Z_LO:  rdata_d = z_lo_q;
                default:             rdata_d = ffm_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_q <= ffm_pkg::RST_BYTE;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata         = rdata_q;
    assign event_active_flag = src_q[ffm_pkg::SRC_EA];
    // Sharing with the transient block is stored only; keeping it apart
    // from the per-axis enable is left to software.
    assign trans_ths_share   = y_hi_q[ffm_pkg::HI_FLAG];
    assign int1_ffmt = src_q[ffm_pkg::SRC_EA] & ffmt_int_enable & ffmt_int_route;
    assign int2_ffmt = src_q[ffm_pkg::SRC_EA] & ffmt_int_enable & ~ffmt_int_route;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    property p_src_ro;
        reg_wr && reg_addr == ffm_pkg::ADDR_SRC && !sample_valid && !reg_rd |=> $stable(src_q);
    endproperty
    a_src_ro: assert property (p_src_ro) else $error("source changed by a write");

    property p_ea_set;
        sample_valid && db_hit |=> src_q[ffm_pkg::SRC_EA];
    endproperty
    a_ea_set: assert property (p_ea_set) else $error("event active not set");

    property p_latch_hold;
        latch && src_q[ffm_pkg::SRC_EA] && !rd_src |=> $stable(src_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flags moved");

    property p_read_clear;
        latch && src_q[ffm_pkg::SRC_EA] && rd_src && !sample_valid |=> src_q == '0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_int_route;
        int1_ffmt || int2_ffmt |-> event_active_flag && ffmt_int_enable
                                   && (int1_ffmt == ffmt_int_route);
    endproperty
    a_int_route: assert property (p_int_route) else $error("interrupt misrouted");

    property p_x_masked;
        rd_src && !axis_en[0] ##1 !(reg_wr || reg_rd) |-> reg_rdata[1:0] == 2'b00;
    endproperty
    a_x_masked: assert property (p_x_masked) else $error("disabled X flags read set");

    property p_motion_any;
        sample_valid && motion && count_q == '0 && |hit && !latch |=> event_active_flag;
    endproperty
    a_motion_any: assert property (p_motion_any) else $error("motion missed");

    c_freefall: cover property (sample_valid && !motion && db_hit);
    c_latched:  cover property (latch && event_active_flag ##[1:20] rd_src);
    c_per_axis: cover property (per_axis && motion && db_hit && sample_valid);
endmodule // ffm_detector

`default_nettype wire

// file: tb/ffm_host_model.sv
`default_nettype none

module ffm_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic own_thr_q;
    logic share_q;

    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        own_thr_q = 1'b0;
        share_q = 1'b0;
    end

    // Lines are inverted after release so a stale value never looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ffm_pkg::ADDR_X_HI && share_q)
            v[7] = 1'b0;
        if (a == ffm_pkg::ADDR_Y_HI && own_thr_q)
            v[7] = 1'b0;
        if (a == ffm_pkg::ADDR_X_HI)
            own_thr_q = v[7];
        if (a == ffm_pkg::ADDR_Y_HI)
            share_q = v[7];
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // ffm_host_model

`default_nettype wire

// file: tb/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ADRS [11] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h73, 8'h74,
        8'h75, 8'h76, 8'h77, 8'h78, 8'h20};
    localparam logic [7:0] EXPV [11] = '{8'hf8, 8'h00, 8'hff, 8'hff, 8'hff, 8'hfc,
        8'h7f, 8'hfc, 8'h7f, 8'hfc, 8'h00};
    localparam logic [11:0] PAT = 12'hbb0;

    logic        sys_clk;
    logic        srst;
    logic        sv;
    logic [13:0] xs;
    logic [13:0] ys;
    logic [13:0] zs;
    logic [1:0]  fs;
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        int_en;
    logic        int_rt;
    logic        int1;
    logic        int2;
    logic        ea;
    logic        share;
    logic [7:0]  cfg;
    logic [7:0]  ths;
    logic [7:0]  cmax;
    logic [7:0]  cnt;
    logic [7:0]  rv;
    logic [7:0]  hi [3];
    logic [7:0]  lo [3];
    int          error_cnt;
    int          n_compared;

    ffm_detector i_dut (
        .sys_clk(sys_clk), .srst(srst), .sample_valid(sv),
        .x_sample(xs), .y_sample(ys), .z_sample(zs), .full_scale_select(fs),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .ffmt_int_enable(int_en), .ffmt_int_route(int_rt),
        .int1_ffmt(int1), .int2_ffmt(int2), .event_active_flag(ea),
        .trans_ths_share(share)
    );

    ffm_host_model i_host (
        .sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] mag(input logic [13:0] s);
        return s[13] ? 16'(~{2'b11, s}) + 16'h0001 : {2'b00, s};
    endfunction

    function automatic logic [15:0] thr_of(input int i);
        if (hi[0][7])
            return {3'b000, hi[i][6:0], lo[i][7:2]};
        return (16'(ths[6:0]) * ffm_pkg::COMMON_STEP_2G) >> fs;
    endfunction

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(a, d);
        if (a == 8'h15)
            cfg = d & 8'hf8;
        if (a == 8'h17)
            ths = d;
        if (a == 8'h18)
            cmax = d;
        if (a[7:4] == 4'h7)
            if (a[0])
                hi[(a - 8'h73) >> 1] = d;
            else
                lo[(a - 8'h74) >> 1] = d;
    endtask

    task automatic drive(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        @(negedge sys_clk);
        xs = x;
        ys = y;
        zs = z;
        sv = 1'b1;
        int_en = 1'($urandom);
        int_rt = 1'($urandom);
        @(negedge sys_clk);
        sv = 1'b0;
        xs = ~x;
        ys = ~y;
        zs = ~z;
    endtask

    // Axis bits are only compared where their meaning is settled: disabled
    // axes, and motion hits when no debounce stands between sample and flag.
    task automatic send(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        logic [13:0] s [3];
        logic [7:0]  e;
        logic [7:0]  m;
        logic [15:0] g;
        logic [15:0] t;
        logic        any_hi;
        logic        all_lo;
        logic        any_en;
        logic        c;
        s = '{x, y, z};
        e = 8'h00;
        m = 8'hc0;
        any_hi = 1'b0;
        all_lo = 1'b1;
        any_en = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            g = mag(s[i]);
            t = thr_of(i);
            if (!cfg[3 + i])
                m[2 * i +: 2] = 2'b11;
            else
            begin
                any_en = 1'b1;
                any_hi |= g > t;
                all_lo &= g < t;
                if (cfg[6] && g > t)
                    e[2 * i +: 2] = {1'b1, s[i][13]};
                if (cfg[6] && cmax == 8'h00)
                    m[2 * i +: 2] = {1'b1, g > t};
            end
        end
        c = cfg[6] ? any_hi : all_lo & any_en;
        if (c)
            cnt = cnt < cmax ? cnt + 8'h01 : cmax;
        else
            cnt = ths[7] || cnt == 8'h00 ? 8'h00 : cnt - 8'h01;
        e[7] = c && cnt == cmax;
        drive(x, y, z);
        check({7'h00, ea}, {7'h00, e[7]});
        check({7'h00, int1}, {7'h00, e[7] & int_en & int_rt});
        check({7'h00, int2}, {7'h00, e[7] & int_en & ~int_rt});
        repeat (2) @(negedge sys_clk);
        check({7'h00, ea}, {7'h00, e[7]});
        i_host.rd(8'h16, rv);
        check(rv & m, e & m);
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end

    initial
    begin
        logic [15:0] t;
        logic [13:0] v [3];
        sys_clk = 1'b0;
        srst = 1'b1;
        sv = 1'b0;
        xs = 14'h0000;
        ys = 14'h0000;
        zs = 14'h0000;
        fs = 2'b00;
        int_en = 1'b0;
        int_rt = 1'b0;
        cfg = 8'h00;
        ths = 8'h00;
        cmax = 8'h00;
        cnt = 8'h00;
        hi = '{default: 8'h00};
        lo = '{default: 8'h00};
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'h4dd4_84c5));
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        for (int i = 0; i < 11; i++)
        begin
            i_host.rd(ADRS[i], rv);
            check(rv, 8'h00);
        end
        for (int i = 0; i < 11; i++)
            wreg(ADRS[i], 8'hff);
        for (int i = 0; i < 11; i++)
        begin
            i_host.rd(ADRS[i], rv);
            check(rv, EXPV[i]);
        end
        check({7'h00, share}, 8'h00);
        wreg(8'h73, 8'h7f);
        wreg(8'h75, 8'h80);
        check({7'h00, share}, 8'h01);
        wreg(8'h75, 8'h00);
        wreg(8'h18, 8'h00);
        wreg(8'h17, 8'h7f);
        wreg(8'h15, 8'h48);
        wreg(8'h73, 8'hff);
        wreg(8'h74, 8'hfc);
        fs = 2'd2;
        send(14'h1fff, 14'h0000, 14'h0000);
        send(14'h2000, 14'h0000, 14'h0000);
        wreg(8'h73, 8'h7f);
        send(14'h2000, 14'h0000, 14'h0000);
        send(14'h1fff, 14'h0000, 14'h0000);
        fs = 2'd0;
        wreg(8'h17, 8'h01);
        send(14'h0102, 14'h0000, 14'h0000);
        send(14'h0103, 14'h0000, 14'h0000);
        send(14'h3efd, 14'h0000, 14'h0000);
        wreg(8'h15, 8'h38);
        send(14'h0000, 14'h0000, 14'h0000);
        send(14'h0000, 14'h0000, 14'h0102);
        send(14'h3eff, 14'h0001, 14'h0001);
        wreg(8'h15, 8'h00);
        send(14'h0000, 14'h0000, 14'h0000);
        wreg(8'h18, 8'h03);
        wreg(8'h74, 8'h08);
        wreg(8'h15, 8'h48);
        for (int k = 0; k < 4; k++)
        begin
            wreg(8'h17, {k[0], 7'h01});
            wreg(8'h73, {k[1], 7'h04});
            for (int j = 0; j < 12; j++)
                send(PAT[j] ? 14'h012c : 14'h0000, 14'h0000, 14'h0000);
        end
        wreg(8'h18, 8'h00);
        wreg(8'h73, 8'h00);
        wreg(8'h17, 8'h01);
        wreg(8'h15, 8'hc8);
        drive(14'h3ed4, 14'h0000, 14'h0000);
        check({7'h00, ea}, 8'h01);
        drive(14'h03e8, 14'h0000, 14'h0000);
        drive(14'h0000, 14'h0000, 14'h0000);
        wreg(8'h16, 8'h00);
        check({7'h00, ea}, 8'h01);
        i_host.rd(8'h16, rv);
        check(rv, 8'h83);
        check({7'h00, ea}, 8'h00);
        i_host.rd(8'h16, rv);
        check(rv, 8'h00);
        wreg(8'h17, 8'h81);
        wreg(8'h15, 8'h48);
        drive(14'h0000, 14'h0000, 14'h0000);
        cnt = 8'h00;
        repeat (40)
        begin
            wreg(8'h15, 8'($urandom) & 8'h78);
            wreg(8'h17, {1'($urandom), 7'($urandom_range(0, 40))});
            wreg(8'h18, 8'($urandom_range(0, 3)));
            for (int a = 8'h73; a < 8'h79; a++)
                wreg(8'(a), 8'($urandom) & (a == 8'h75 ? 8'h7f : 8'hff));
            fs = 2'($urandom_range(0, 2));
            repeat (6)
            begin
                for (int i = 0; i < 3; i++)
                begin
                    t = thr_of(i) + 16'($urandom_range(0, 2)) - 16'h0001;
                    t = t > 16'h1fff ? 16'h1fff : t;
                    v[i] = $urandom_range(0, 1) ? 14'(-t) : 14'(t);
                    if ($urandom_range(0, 3) == 0)
                        v[i] = 14'($urandom);
                end
                send(v[0], v[1], v[2]);
            end
        end
        finish_test();
    end
endmodule // tb

`default_nettype wire
